// File: design/rca_pkg.sv
`default_nettype none
package rca_pkg;
  // ----------------------------------------------------------------
  // widths and bus
  // ----------------------------------------------------------------
  localparam int VAL_W = 16;
  localparam int ADC_W = 14;
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SUP_TO = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SUP_CNT = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_DIG = 8'h10;
  localparam logic [ADDR_W-1:0] REG_LIM = 8'h20;
  localparam logic [ADDR_W-1:0] REG_OVP = 8'h30;
  localparam logic [ADDR_W-1:0] REG_ACT = 8'h34;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_LOCK = 0;
  localparam int CTRL_SUP_EN = 1;
  localparam int CTRL_DC_OFF = 2;
  localparam int CTRL_RANGE_HI = 3;
  localparam int CTRL_R_MODE = 4;
  localparam int STAT_EXPIRED = 4;
  localparam int STAT_DIG_ERR = 5;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [15:0] TO_RST = 16'h03e8;
  localparam logic [VAL_W-1:0] LIM_RST = 16'hffff;
  localparam logic [VAL_W-1:0] OVP_RST = 16'hffff;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_MANUAL, ST_REMOTE_DIG, ST_REMOTE_ANA, ST_LOCKED} rca_loc_t;
  typedef struct packed {
    logic [VAL_W-1:0] v;
    logic [VAL_W-1:0] c;
    logic [VAL_W-1:0] p;
    logic [VAL_W-1:0] r;
  } rca_setp_t;
  typedef struct packed {
    logic [ADC_W-1:0] v;
    logic [ADC_W-1:0] c;
    logic [ADC_W-1:0] p;
    logic [ADC_W-1:0] r;
  } rca_code_t;
  typedef struct packed {
    logic [ADC_W-1:0] v;
    logic [ADC_W-1:0] c;
  } rca_mon_t;
endpackage
`default_nettype wire

// File: design/rca_top.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - only one remote owner: analog or a single digital interface.
// - digital request during analog control is refused with an error pulse.
// - analog select changes are ignored while a digital interface owns control.
// - register reads work in every location, also after refused requests.
// - free location runs manual values and accepts analog or digital requests.
// - local lock ends digital control; host must request again afterwards.
// - local lock suspends analog; it resumes when select is still low.
// - entering digital control keeps the last set values until host writes.
// - supervision runs only for the owning digital interface under remote.
// - every owner message reloads the supervision timer fully.
// - timer expiry leaves remote; dc input off or kept per setting.
// - supervision enable is writable at any time.
// - a new timeout is used only from the next interval on.
// - supervision timer is independent of any network connection timeout.
// - analog gives voltage, current, power together; resistance optionally.
// - overvoltage and alarm thresholds cannot be set from the analog port.
// - displayed set values follow the analog inputs under analog control; resistance only with r mode, else manual.
// - low range: 5 V reference, 0..5 V maps to full scale.
// - high range: 10 V reference, 0..10 V maps to full scale.
// - every set value is clipped to its adjustment limit.
// - select input low requests analog control, high means manual.
module rca_top
  import rca_pkg::*;
#(
  parameter int N_DIG = 2,
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int TO_W = 16
) (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // digital interfaces
  input wire logic [N_DIG-1:0] I_DIG_REQ,
  input wire logic [N_DIG-1:0] I_DIG_REL,
  input wire logic [N_DIG-1:0] I_DIG_MSG,
  output logic [N_DIG-1:0] O_DIG_ERR,
  // analog port
  input wire logic I_REMOTE_SEL_N,
  input wire rca_code_t I_ANA_CODE,
  output logic O_VREF_HIGH,
  output var rca_mon_t O_MON,
  // set values and actual values
  input wire rca_setp_t I_MAN_SETP,
  input wire logic [VAL_W-1:0] I_ACT_V,
  input wire logic [VAL_W-1:0] I_ACT_C,
  output var rca_setp_t O_DISP_SETP,
  output var rca_setp_t O_SETP,
  output logic [VAL_W-1:0] O_OVP_THR,
  // dc input and location
  input wire logic I_DC_ON,
  output logic O_DC_OFF_REQ,
  output var rca_loc_t O_LOC
);
  localparam int OWN_W = (N_DIG > 1) ? $clog2(N_DIG) : 1;
  localparam int TW = $clog2(TICK_CYCLES);
  rca_loc_t loc;
  logic [OWN_W-1:0] owner, dig_pick;
  logic dig_any, tick, aw_full, w_full, wr_do, st_expired, st_dig_err;
  logic [4:0] ctrl_q;
  logic [TO_W-1:0] to_pending, sup_cnt;
  logic [3:0][VAL_W-1:0] dig_q, lim_q, setp_q, next_arr;
  rca_setp_t next_disp;
  logic [VAL_W-1:0] ovp_q;
  logic [TW-1:0] tick_cnt;
  logic [ADDR_W-1:0] aw_addr, wa;
  logic [31:0] w_data_q, rd_word, wr_word;
  logic [3:0] w_strb_q;
  logic [7:0] st_clr;
  wire logic lock = ctrl_q[CTRL_LOCK];
  wire logic hi = ctrl_q[CTRL_RANGE_HI];
  wire logic analog_req = !I_REMOTE_SEL_N;
  wire logic own_rel = (loc == ST_REMOTE_DIG) && I_DIG_REL[owner];
  wire logic own_msg = (loc == ST_REMOTE_DIG) && I_DIG_MSG[owner];
  wire logic enter_dig = (loc == ST_MANUAL) && !lock && !analog_req && dig_any;
  wire logic sup_run = (loc == ST_REMOTE_DIG) && ctrl_q[CTRL_SUP_EN];
  wire logic sup_expire = sup_run && !lock && tick && !own_msg && (sup_cnt <= TO_W'(1)); // lock wins over expiry
  assign O_LOC = loc;
  assign O_SETP = setp_q;
  assign next_arr = next_disp;
  assign wa = {aw_addr[ADDR_W-1:2], 2'b00};
  assign wr_do = aw_full && w_full && !O_BVALID;
  assign st_clr = (wr_do && wa == REG_STATUS && w_strb_q[0]) ? w_data_q[7:0] : 8'h00;

  // ----------------------------------------------------------------
  // register access helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] reg_read(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'b00};
    reg_read = 32'h0000_0000;
    if (w == REG_CTRL) reg_read = 32'(ctrl_q);
    else if (w == REG_STATUS) reg_read = 32'({st_dig_err, st_expired, 2'(owner), loc});
    else if (w == REG_SUP_TO) reg_read = 32'(to_pending);
    else if (w == REG_SUP_CNT) reg_read = 32'(sup_cnt);
    else if (w[ADDR_W-1:4] == REG_DIG[ADDR_W-1:4]) reg_read = 32'(dig_q[~w[3:2]]);
    else if (w[ADDR_W-1:4] == REG_LIM[ADDR_W-1:4]) reg_read = 32'(lim_q[~w[3:2]]);
    else if (w == REG_OVP) reg_read = 32'(ovp_q);
    else if (w == REG_ACT) reg_read = {I_ACT_C, I_ACT_V};
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
    return r;
  endfunction

  function automatic logic [VAL_W-1:0] ana_frac(input logic [ADC_W-1:0] code, input logic h);
    if (h) ana_frac = VAL_W'(code) << (VAL_W - ADC_W);
    else if (code[ADC_W-1]) ana_frac = '1;
    else ana_frac = VAL_W'(code) << (VAL_W - ADC_W + 1);
  endfunction

  always_comb begin
    rd_word = reg_read(I_ARADDR);
    wr_word = wmerge(reg_read(wa), w_data_q, w_strb_q);
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
      O_AWREADY <= 1'b0;
    end else if (O_AWREADY && I_AWVALID) begin
      aw_full <= 1'b1;
      aw_addr <= I_AWADDR;
      O_AWREADY <= 1'b0;
    end else if (wr_do) begin
      aw_full <= 1'b0;
      O_AWREADY <= 1'b1;
    end else if (!aw_full) begin
      O_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      w_full <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      O_WREADY <= 1'b0;
    end else if (O_WREADY && I_WVALID) begin
      w_full <= 1'b1;
      w_data_q <= I_WDATA;
      w_strb_q <= I_WSTRB;
      O_WREADY <= 1'b0;
    end else if (wr_do) begin
      w_full <= 1'b0;
      O_WREADY <= 1'b1;
    end else if (!w_full) begin
      O_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_BVALID <= 1'b0;
      O_BRESP <= RESP_OKAY;
    end else if (wr_do) begin
      O_BVALID <= 1'b1;
      O_BRESP <= (wa <= REG_ACT) ? RESP_OKAY : RESP_SLVERR;
    end else if (I_BREADY) begin
      O_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= '0;
      O_RRESP <= RESP_OKAY;
    end else if (O_ARREADY && I_ARVALID) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b1;
      O_RDATA <= rd_word;
      O_RRESP <= ({I_ARADDR[ADDR_W-1:2], 2'b00} <= REG_ACT) ? RESP_OKAY : RESP_SLVERR;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'b0;
      O_ARREADY <= 1'b1;
    end else if (!O_RVALID) begin
      O_ARREADY <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_q <= CTRL_RST;
      to_pending <= TO_W'(TO_RST);
      lim_q <= {4{LIM_RST}};
      ovp_q <= OVP_RST;
    end else if (wr_do) begin
      if (wa == REG_CTRL) ctrl_q <= wr_word[4:0];
      else if (wa == REG_SUP_TO) to_pending <= wr_word[TO_W-1:0];
      else if (wa[ADDR_W-1:4] == REG_LIM[ADDR_W-1:4]) lim_q[~wa[3:2]] <= wr_word[VAL_W-1:0];
      else if (wa == REG_OVP) ovp_q <= wr_word[VAL_W-1:0];
    end
  end

  // sticky status, set beats write-one-to-clear
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_expired <= 1'b0;
      st_dig_err <= 1'b0;
    end else begin
      if (sup_expire) st_expired <= 1'b1;
      else if (st_clr[STAT_EXPIRED]) st_expired <= 1'b0;
      if (|O_DIG_ERR) st_dig_err <= 1'b1;
      else if (st_clr[STAT_DIG_ERR]) st_dig_err <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control location arbiter
  // ----------------------------------------------------------------
  always_comb begin
    dig_any = 1'b0;
    dig_pick = '0;
    for (int i = N_DIG - 1; i >= 0; i--) begin
      if (I_DIG_REQ[i]) begin
        dig_any = 1'b1;
        dig_pick = OWN_W'(i);
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      loc <= ST_MANUAL;
      owner <= '0;
    end else begin
      case (loc)
        ST_MANUAL: begin
          if (lock) loc <= ST_LOCKED;
          else if (analog_req) loc <= ST_REMOTE_ANA;
          else if (dig_any) begin
            loc <= ST_REMOTE_DIG;
            owner <= dig_pick;
          end
        end
        ST_REMOTE_ANA: begin
          if (lock) loc <= ST_LOCKED;
          else if (!analog_req) loc <= ST_MANUAL;
        end
        ST_REMOTE_DIG: begin
          // select input is not looked at here
          if (lock) loc <= ST_LOCKED;
          else if (sup_expire || own_rel) loc <= ST_MANUAL;
        end
        default: begin
          // analog comes back through manual if select is still low
          if (!lock) loc <= ST_MANUAL;
        end
      endcase
    end
  end

  for (genvar g = 0; g < N_DIG; g++) begin : g_dig
    wire logic grant = (enter_dig && dig_pick == OWN_W'(g)) ||
                       (loc == ST_REMOTE_DIG && !lock && owner == OWN_W'(g));
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
      if (!I_RST_N) O_DIG_ERR[g] <= 1'b0;
      else O_DIG_ERR[g] <= I_DIG_REQ[g] && !grant;
    end
  end

  // ----------------------------------------------------------------
  // communication supervision
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  // own tick only, no link timeout feeds it
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) sup_cnt <= '0;
    else if (!sup_run || own_msg) sup_cnt <= to_pending;
    else if (tick && sup_cnt != '0) sup_cnt <= sup_cnt - 1'b1;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) O_DC_OFF_REQ <= 1'b0;
    else O_DC_OFF_REQ <= sup_expire && I_DC_ON && ctrl_q[CTRL_DC_OFF];
  end

  // ----------------------------------------------------------------
  // set value sources, clipping and analog scaling
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) dig_q <= '0;
    else if (enter_dig) dig_q <= O_DISP_SETP;
    else if (wr_do && wa[ADDR_W-1:4] == REG_DIG[ADDR_W-1:4]) dig_q[~wa[3:2]] <= wr_word[VAL_W-1:0];
  end

  always_comb begin
    next_disp = I_MAN_SETP;
    if (loc == ST_REMOTE_DIG) begin
      next_disp = dig_q;
    end else if (loc == ST_REMOTE_ANA) begin
      next_disp.v = ana_frac(I_ANA_CODE.v, hi);
      next_disp.c = ana_frac(I_ANA_CODE.c, hi);
      next_disp.p = ana_frac(I_ANA_CODE.p, hi);
      if (ctrl_q[CTRL_R_MODE]) next_disp.r = ana_frac(I_ANA_CODE.r, hi);
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_DISP_SETP <= '0;
      setp_q <= '0;
    end else begin
      O_DISP_SETP <= next_disp;
      for (int i = 0; i < 4; i++) setp_q[i] <= (next_arr[i] > lim_q[i]) ? lim_q[i] : next_arr[i];
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_VREF_HIGH <= 1'b0;
      O_MON <= '0;
      O_OVP_THR <= OVP_RST;
    end else begin
      O_VREF_HIGH <= hi;
      O_MON.v <= hi ? I_ACT_V[VAL_W-1 -: ADC_W] : {1'b0, I_ACT_V[VAL_W-1 -: ADC_W-1]};
      O_MON.c <= hi ? I_ACT_C[VAL_W-1 -: ADC_W] : {1'b0, I_ACT_C[VAL_W-1 -: ADC_W-1]};
      O_OVP_THR <= ovp_q;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  a_analog_refuse: assert property (loc == ST_REMOTE_ANA && I_DIG_REQ[0] |=> O_DIG_ERR[0])
    else $error("digital request not refused under analog control");
  a_select_ignored: assert property (loc == ST_REMOTE_DIG && !lock && !own_rel && !sup_expire
    |=> loc == ST_REMOTE_DIG)
    else $error("digital control lost without cause");
  a_lock_ends: assert property (lock && loc != ST_LOCKED
    |=> loc == ST_LOCKED ##1 (lock || loc != ST_REMOTE_DIG))
    else $error("local lock did not take over");
  a_analog_resume: assert property (loc == ST_LOCKED && !lock ##1 analog_req && !lock
    |=> loc == ST_REMOTE_ANA)
    else $error("analog control did not resume after lock");
  a_dig_keeps: assert property (enter_dig && !wr_do |=> dig_q == $past(O_DISP_SETP))
    else $error("set values changed on entering digital control");
  a_sup_idle: assert property (!sup_run |=> sup_cnt == $past(to_pending))
    else $error("supervision counter moved while idle");
  a_msg_reload: assert property (sup_run && own_msg |=> sup_cnt == $past(to_pending))
    else $error("message did not reload the timer");
  a_expiry_exit: assert property (sup_expire |=> loc == ST_MANUAL && st_expired &&
    O_DC_OFF_REQ == $past(I_DC_ON && ctrl_q[CTRL_DC_OFF]))
    else $error("wrong reaction to supervision expiry");
  a_clip_limit: assert property (1'b1 |=> setp_q[3] <= $past(lim_q[3]) && setp_q[2] <= $past(lim_q[2]))
    else $error("set value above its limit");
  a_analog_disp: assert property (loc == ST_REMOTE_ANA && hi
    |=> O_DISP_SETP.v == {$past(I_ANA_CODE.v), 2'b00})
    else $error("display does not follow analog input");
  a_vref_range: assert property ($changed(hi) |=> ##[0:1] O_VREF_HIGH == hi)
    else $error("reference range not following setting");
endmodule
`default_nettype wire

// File: test/rca_ana_model.sv
`timescale 1ns/1ns
`default_nettype none
module rca_ana_model
  import rca_pkg::*;
(
  // control from bench
  input wire logic i_wired,
  input wire logic i_ext,
  input wire rca_code_t i_code,
  // analog pins
  output logic o_remote_sel_n,
  output var rca_code_t o_code
);
  // an unwired select floats high through its pull-up
  assign o_remote_sel_n = i_wired ? !i_ext : 1'b1;
  // set values are always driven, the device uses them only once select is low
  assign o_code = i_code;
endmodule
`default_nettype wire

// File: test/remote_control_arbiter_tb.sv
`timescale 1ns/1ns
`default_nettype none
module remote_control_arbiter_tb
  import rca_pkg::*;
;
  localparam int TK = 4;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, wired = 0, ext = 0, dc_on = 0;
  logic awrdy, wrdy, bvld, arrdy, rvld, vref_hi, dc_off, sel_n;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [1:0] bresp, rresp, err, err_seen = 0, req = 0, rel = 0, msg = 0;
  logic [15:0] act_v = 0, act_c = 0, overvoltage_threshold;
  logic [63:0] t;
  rca_code_t code = {14'h1000, 14'h2000, 14'h0001, 14'h0100}, ana;
  rca_mon_t mon;
  rca_setp_t man = '0, disp, setp;
  rca_loc_t loc;
  logic [33:0] exp_q[$];
  int mismatches = 0, total_checks = 0, seed = 54686, dc_off_seen = 0;
  rca_top #(.TICK_CYCLES(TK)) dut (
    .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awrdy),
    .I_WDATA(wd), .I_WSTRB(4'hf), .I_WVALID(wv), .O_WREADY(wrdy), .O_BRESP(bresp), .O_BVALID(bvld),
    .I_BREADY(br), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arrdy), .O_RDATA(rd), .O_RRESP(rresp),
    .O_RVALID(rvld), .I_RREADY(rr), .I_DIG_REQ(req), .I_DIG_REL(rel), .I_DIG_MSG(msg), .O_DIG_ERR(err),
    .I_REMOTE_SEL_N(sel_n), .I_ANA_CODE(ana), .O_VREF_HIGH(vref_hi), .O_MON(mon), .I_MAN_SETP(man),
    .I_ACT_V(act_v), .I_ACT_C(act_c), .O_DISP_SETP(disp), .O_SETP(setp), .O_OVP_THR(overvoltage_threshold),
    .I_DC_ON(dc_on), .O_DC_OFF_REQ(dc_off), .O_LOC(loc));
  rca_ana_model model (.i_wired(wired), .i_ext(ext), .i_code(code), .o_remote_sel_n(sel_n), .o_code(ana));
  initial begin
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tmo(inout int n);
    n++;
    if (n > 40) begin
      mismatches++;
      close_out();
    end
  endtask
  // read results are compared in arrival order
  always @(negedge clk) begin
    if (rvld === 1'b1 && rr === 1'b1) begin
      chk(64'({rresp, rd}), 64'(exp_q.pop_front()));
    end
    err_seen = err_seen | err;
    if (dc_off === 1'b1) begin
      dc_off_seen = 1;
    end
  end
  // ----------------------------------------------------------------
  // bus and pin drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, ad, dd, bh;
    int n;
    n = 0;
    ad = 0;
    dd = 0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!(ad && dd)) begin
      @(negedge clk);
      ah = awrdy && !ad;
      wh = wrdy && !dd;
      @(posedge clk);
      if (ah) begin
        awv <= 1'b0;
        ad = 1;
      end
      if (wh) begin
        wv <= 1'b0;
        dd = 1;
      end
      tmo(n);
    end
    do begin
      @(negedge clk);
      bh = bvld;
      if (bh) begin
        chk(64'(bresp), 64'(er));
      end
      @(posedge clk);
      tmo(n);
    end while (!bh);
    br <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic h;
    int n;
    n = 0;
    exp_q.push_back({er, d});
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(negedge clk);
      h = arrdy;
      @(posedge clk);
      tmo(n);
    end while (!h);
    arv <= 1'b0;
    do begin
      @(negedge clk);
      h = rvld;
      @(posedge clk);
      tmo(n);
    end while (!h);
    rr <= 1'b0;
  endtask
  task automatic pulse(input int k, input int i);
    @(posedge clk);
    if (k == 0) req <= 2'(1 << i);
    if (k == 1) rel <= 2'(1 << i);
    if (k == 2) msg <= 2'(1 << i);
    @(posedge clk);
    req <= 2'h0;
    rel <= 2'h0;
    msg <= 2'h0;
    @(negedge clk);
    // let the error watcher sample this edge first
    #1;
  endtask
  task automatic wait_loc(input rca_loc_t e);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      tmo(n);
    end while (loc !== e);
    chk(64'(loc), 64'(e));
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdx(REG_CTRL, 32'h0, RESP_OKAY);
    rdx(REG_SUP_TO, 32'h3e8, RESP_OKAY);
    rdx(REG_LIM, 32'hffff, RESP_OKAY);
    rdx(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    $display("test reset done");
    t = {$random(seed), $random(seed)};
    t[63] = 1'b1;
    act_v <= 16'($random(seed));
    act_c <= 16'($random(seed));
    man <= t;
    repeat (3) @(posedge clk);
    chk(setp, t);
    wr(REG_LIM, 32'h1000, RESP_OKAY);
    wr(REG_OVP, 32'h5a5a, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk(64'(setp.v), 64'h1000);
    pulse(0, 1);
    wait_loc(ST_REMOTE_DIG);
    rdx(REG_DIG, 32'(t[63:48]), RESP_OKAY);
    wired <= 1'b1;
    ext <= 1'b1;
    repeat (4) @(posedge clk);
    chk(64'(loc), 64'(ST_REMOTE_DIG));
    err_seen = 0;
    pulse(0, 0);
    chk(64'(err_seen), 64'h1);
    pulse(1, 1);
    wait_loc(ST_REMOTE_ANA);
    err_seen = 0;
    pulse(0, 0);
    chk(64'(err_seen), 64'h1);
    chk(64'(loc), 64'(ST_REMOTE_ANA));
    rdx(REG_ACT, {act_c, act_v}, RESP_OKAY);
    chk(64'(disp[63:16]), 64'h8000_ffff_0008);
    chk(64'(setp.v), 64'h1000);
    chk(64'(disp.r), 64'(t[15:0]));
    chk(64'({vref_hi, mon.v}), 64'({1'b0, 1'b0, act_v[15:3]}));
    rdx(REG_OVP, 32'h5a5a, RESP_OKAY);
    chk(64'(overvoltage_threshold), 64'h5a5a);
    wr(REG_CTRL, 32'h8, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk(64'({vref_hi, disp.v}), 64'h1_4000);
    chk(64'(mon.v), 64'(act_v[15:2]));
    chk(64'(mon.c), 64'(act_c[15:2]));
    wr(REG_CTRL, 32'h18, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk(64'(disp.r), 64'h0400);
    wr(REG_CTRL, 32'h9, RESP_OKAY);
    wait_loc(ST_LOCKED);
    wr(REG_CTRL, 32'h8, RESP_OKAY);
    wait_loc(ST_REMOTE_ANA);
    ext <= 1'b0;
    wait_loc(ST_MANUAL);
    $display("test analog done");
    pulse(0, 0);
    wait_loc(ST_REMOTE_DIG);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    wait_loc(ST_LOCKED);
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    wait_loc(ST_MANUAL);
    repeat (5) @(posedge clk);
    chk(64'(loc), 64'(ST_MANUAL));
    wr(REG_SUP_TO, 32'h3, RESP_OKAY);
    pulse(0, 1);
    wait_loc(ST_REMOTE_DIG);
    repeat (40) @(posedge clk);
    chk(64'(loc), 64'(ST_REMOTE_DIG));
    rdx(REG_SUP_CNT, 32'h3, RESP_OKAY);
    dc_on <= 1'b1;
    wr(REG_CTRL, 32'h6, RESP_OKAY);
    repeat (6) begin
      pulse(2, 1);
      @(posedge clk);
    end
    chk(64'(loc), 64'(ST_REMOTE_DIG));
    wr(REG_SUP_TO, 32'h32, RESP_OKAY);
    wait_loc(ST_MANUAL);
    @(posedge clk);
    chk(64'(dc_off_seen), 64'h1);
    rdx(REG_STATUS, 32'h34, RESP_OKAY);
    wr(REG_STATUS, 32'h30, RESP_OKAY);
    rdx(REG_STATUS, 32'h4, RESP_OKAY);
    $display("test supervision done");
    close_out();
  end
endmodule
`default_nettype wire
